// File: hdl/trc_replay_ctl.sv
`default_nettype none
`include "trc_regs.svh"
module trc_replay_ctl #(
	parameter int DATA_W = `TRC_DATA_W,
	parameter int FIFO_DEPTH = `TRC_FIFO_DEPTH,
	parameter int SYM_DIV = `TRC_SYM_DIV
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic tlValid,
	input wire logic [DATA_W-1:0] tlData,
	output logic tlReady,
	output logic txValid,
	output logic [DATA_W-1:0] txData,
	input wire logic txReady,
	input wire logic txLastSym,
	input wire logic txIsRetx,
	input wire logic ackRcvd,
	input wire logic ackAdvances,
	input wire logic nakRcvd,
	input wire logic unackPending,
	input wire logic linkUp,
	input wire logic ltssmRetrain,
	input wire logic retrainDone,
	input wire logic replayDone,
	input wire logic [2:0] maxPayload,
	input wire logic [4:0] linkLanes,
	input wire logic [`TRC_TMR_W-1:0] rxL0sAdj,
	input wire logic ackLinkL0sExit,
	output logic replayStart,
	output logic replayActive,
	output logic retrainReq,
	output logic portError,
	output logic [1:0] replayNum,
	output logic timerRunning,
	output trc_pkg::trc_count_t timerCount
);
	trc_pkg::trc_state_t state_q;
	trc_pkg::trc_state_t state_d;
	trc_pkg::trc_count_t thresh_q;
	trc_pkg::trc_count_t calcThresh;
	logic [15:0] symDiv_q;
	logic firstRetx_q;
	logic fifoAlmost;
	logic fifoOutValid;
	logic [DATA_W-1:0] fifoOutData;

	// Symbol-time enable; divider of one ticks every clock
	wire symEn = symDiv_q == 16'(SYM_DIV - 1);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			symDiv_q <= '0;
		end else begin
			symDiv_q <= symEn ? '0 : symDiv_q + 16'h0001;
		end
	end

	// Payload code comes in from the configured maximum
	// Receiver L0s adjustment is applied inside the calculator
	trc_timeout uTimeout (
		.mclk(mclk),
		.nrst(nrst),
		.maxPayload(maxPayload),
		.linkLanes(linkLanes),
		.rxL0sAdj(rxL0sAdj),
		.threshold(calcThresh)
	);

	// Replay state decode
	wire inReplay = state_q != trc_pkg::ST_IDLE;
	wire blockNew = state_d != trc_pkg::ST_IDLE;
	wire wrapNext = replayNum == `TRC_RNUM_WRAP;

	// Expiry deferred while the Ack link leaves L0s
	wire atThresh = timerRunning && timerCount >= thresh_q;
	wire expire = atThresh && !ackLinkL0sExit;

	wire holdClear = !linkUp || !unackPending || expire || (nakRcvd && !inReplay);
	// First resent packet finishing restarts the timer
	wire retxRestart = firstRetx_q && txLastSym && txIsRetx;
	// Only an Ack that frees buffer entries restarts
	wire ackRestart = ackRcvd && ackAdvances;
	wire restart = retxRestart || ackRestart;
	// Plain start when not already counting
	wire start = txLastSym && !timerRunning;
	wire advance = timerRunning && symEn && !ltssmRetrain && !atThresh;

	// Replay triggered by Nak or by timer expiry
	wire trigger = linkUp && !inReplay && (nakRcvd || expire);

	// Timer count, running flag and latched threshold
	// Counting spans last symbol of oldest packet to resend
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			timerRunning <= 1'b0;
			timerCount <= '0;
			thresh_q <= '1;
		end else if (holdClear) begin
			// Nothing outstanding keeps the timer at zero
			timerRunning <= 1'b0;
			timerCount <= '0;
		end else if (restart || start) begin
			timerRunning <= 1'b1;
			timerCount <= '0;
			// New width or payload applies from this start
			thresh_q <= calcThresh;
		end else if (advance) begin
			timerCount <= timerCount + 1'b1;
		end
	end

	// Next replay state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			trc_pkg::ST_IDLE: begin
				if (trigger) begin
					state_d = trc_pkg::ST_CHECK;
				end
			end
			trc_pkg::ST_CHECK: begin
				// Nothing left to resend ends the replay here
				if (!unackPending) begin
					state_d = trc_pkg::ST_IDLE;
				end else if (wrapNext) begin
					state_d = trc_pkg::ST_RETRAIN;
				end else begin
					state_d = trc_pkg::ST_REPLAY;
				end
			end
			trc_pkg::ST_RETRAIN: begin
				// Resend only once retraining has completed
				if (retrainDone) begin
					state_d = trc_pkg::ST_REPLAY;
				end
			end
			trc_pkg::ST_REPLAY: begin
				if (replayDone) begin
					state_d = trc_pkg::ST_IDLE;
				end
			end
		endcase
		// Link down drops back to inactive
		if (!linkUp) begin
			state_d = trc_pkg::ST_IDLE;
		end
	end

	// Entry into the resend phase
	wire enterReplay = state_d == trc_pkg::ST_REPLAY && state_q != trc_pkg::ST_REPLAY;
	wire checkPass = state_q == trc_pkg::ST_CHECK && unackPending && linkUp;

	// State, replay counter and event pulses
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= trc_pkg::ST_IDLE;
			replayNum <= '0;
			replayStart <= 1'b0;
			replayActive <= 1'b0;
			retrainReq <= 1'b0;
			portError <= 1'b0;
		end else begin
			state_q <= state_d;
			replayActive <= blockNew;
			replayStart <= enterReplay;
			// Wrap asks for retraining and flags a port error
			retrainReq <= checkPass && wrapNext;
			portError <= checkPass && wrapNext;
			// Counter survives retrain, cleared on link down
			if (!linkUp) begin
				replayNum <= '0;
			end else if (checkPass) begin
				replayNum <= replayNum + 1'b1;
			end else if (ackRestart && !inReplay) begin
				replayNum <= '0;
			end
		end
	end

	// First resent packet marker for the restart point
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			firstRetx_q <= 1'b0;
		end else if (!linkUp || retxRestart) begin
			firstRetx_q <= 1'b0;
		end else if (enterReplay) begin
			firstRetx_q <= 1'b1;
		end
	end

	// New packets buffered ahead of the transmitter
	wire fifoPush = tlValid && tlReady;
	wire outFree = !txValid || txReady;
	wire fifoPop = fifoOutValid && outFree && !inReplay;

	trc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.mclk(mclk),
		.nrst(nrst),
		.inValid(fifoPush),
		.inReady(),
		.almostFull(fifoAlmost),
		.inData(tlData),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);

	// Ready is registered one slot early so a push never overflows
	// Transaction layer is held off during any replay
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tlReady <= 1'b0;
		end else begin
			tlReady <= !fifoAlmost && !blockNew;
		end
	end

	// Output stage; stalls on txReady so the FIFO can fill
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			txValid <= 1'b0;
			txData <= '0;
		end else if (outFree) begin
			txValid <= fifoPop;
			if (fifoPop) begin
				txData <= fifoOutData;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	start_timer_a: assert property (!timerRunning && txLastSym && !holdClear |=> timerRunning && timerCount == 0)
		else $error("timer did not start at last symbol");
	retx_restart_a: assert property (retxRestart && !holdClear |=> timerRunning && timerCount == 0)
		else $error("timer not restarted by first resend");
	ack_restart_a: assert property (timerRunning && ackRcvd && !ackAdvances && !holdClear && !retxRestart && advance
		|=> timerCount == $past(timerCount) + 1)
		else $error("stale ack restarted timer");
	nak_clear_a: assert property (nakRcvd && !inReplay |=> !timerRunning && timerCount == 0)
		else $error("nak did not clear timer");
	retrain_freeze_a: assert property (ltssmRetrain && !holdClear && !restart |=> timerCount == $past(timerCount))
		else $error("timer advanced during retraining");
	idle_clear_a: assert property (!unackPending |=> !timerRunning && timerCount == 0)
		else $error("timer running with nothing outstanding");
	trigger_replay_a: assert property (trigger |=> state_q == trc_pkg::ST_CHECK ##0 replayActive)
		else $error("replay not started on trigger");
	empty_abort_a: assert property (state_q == trc_pkg::ST_CHECK && !unackPending
		|=> state_q == trc_pkg::ST_IDLE && !replayStart ##1 !replayStart)
		else $error("empty buffer replay not abandoned");
	wrap_retrain_a: assert property (checkPass && replayNum == 2'h3
		|=> retrainReq && portError && replayNum == 2'h0 && !replayStart)
		else $error("counter wrap did not request retrain");
	link_down_a: assert property (!linkUp |=> !replayActive && !timerRunning && replayNum == 2'h0)
		else $error("link down left state behind");
	block_new_a: assert property (replayActive |-> !tlReady && !fifoPop)
		else $error("new packet accepted during replay");
	thresh_bound_a: assert property (timerRunning && !restart |=> timerCount <= thresh_q)
		else $error("timer passed its threshold");
	l0s_defer_a: assert property (atThresh && ackLinkL0sExit && linkUp && unackPending && !nakRcvd
		|=> timerRunning)
		else $error("replay fired during L0s exit");

	nak_replay_c: cover property (nakRcvd && !inReplay ##1 state_q == trc_pkg::ST_CHECK ##[1:4] replayStart);
	expiry_replay_c: cover property (expire ##[1:4] replayStart);
	wrap_retrain_c: cover property (retrainReq ##[1:50] replayStart);
	fifo_stall_c: cover property (fifoAlmost && txValid && !txReady);
endmodule
`default_nettype wire

// File: hdl/trc_regs.svh
`ifndef TRC_REGS_SVH
`define TRC_REGS_SVH
// Timeout formula constants, in symbols or symbol times
`define TRC_TLP_OVERHEAD 28
`define TRC_INTERNAL_DELAY 19
`define TRC_TIMEOUT_MULT 3
// Ack factors scaled by ten
`define TRC_AF_SCALE 10
`define TRC_AF_SMALL_NARROW 14
`define TRC_AF_SMALL_X8 25
`define TRC_AF_SMALL_WIDE 30
`define TRC_AF_LARGE_NARROW 10
`define TRC_AF_LARGE_WIDE 20
// Payload code 0 means 128 bytes, each step doubles
`define TRC_MPS_BASE 128
`define TRC_MPS_SMALL_MAX 3'h1
`define TRC_LANES_NARROW_MAX 5'h04
`define TRC_LANES_X8 5'h08
// Replay counter value that wraps on the next replay
`define TRC_RNUM_WRAP 2'h3
`define TRC_TMR_W 16
`define TRC_SYM_DIV 1
`define TRC_FIFO_DEPTH 16
`define TRC_DATA_W 32
`endif

// File: hdl/trc_pkg.sv
`default_nettype none
`include "trc_regs.svh"
package trc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_RETRAIN, ST_REPLAY} trc_state_t;
	typedef logic [`TRC_TMR_W-1:0] trc_count_t;
endpackage
`default_nettype wire

// File: hdl/trc_fifo.sv
`default_nettype none
`include "trc_regs.svh"
module trc_fifo #(
	parameter int WIDTH = `TRC_DATA_W,
	parameter int DEPTH = `TRC_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	output logic almostFull,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;

	// Honest flags straight from the occupancy count
	assign inReady = count_q != DEPTH[AW:0];
	assign almostFull = count_q >= DEPTH[AW:0] - {{AW{1'b0}}, 1'b1};
	assign outValid = count_q != '0;
	assign outData = mem_q[rdPtr_q];

	// Storage, no reset needed on data
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	// Pointers wrap at the depth, not the power of two
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule
`default_nettype wire

// File: hdl/trc_timeout.sv
`default_nettype none
`include "trc_regs.svh"
module trc_timeout (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [2:0] maxPayload,
	input wire logic [4:0] linkLanes,
	input wire logic [`TRC_TMR_W-1:0] rxL0sAdj,
	output trc_pkg::trc_count_t threshold
);
	// Unadjusted timeout from payload and width
	function automatic trc_pkg::trc_count_t trc_unadj(input logic [2:0] mps, input logic [4:0] lanes);
		int bytes;
		int af;
		int ln;
		int lat;
		bytes = `TRC_MPS_BASE << mps;
		ln = (lanes == 5'h00) ? 1 : int'(lanes);
		if (mps <= `TRC_MPS_SMALL_MAX) begin
			af = (lanes <= `TRC_LANES_NARROW_MAX) ? `TRC_AF_SMALL_NARROW :
				(lanes == `TRC_LANES_X8) ? `TRC_AF_SMALL_X8 : `TRC_AF_SMALL_WIDE;
		end else begin
			af = (lanes <= `TRC_LANES_NARROW_MAX) ? `TRC_AF_LARGE_NARROW : `TRC_AF_LARGE_WIDE;
		end
		// Fixed packet overhead, fixed internal delay
		lat = ((bytes + `TRC_TLP_OVERHEAD) * af) / (`TRC_AF_SCALE * ln) + `TRC_INTERNAL_DELAY;
		return trc_pkg::trc_count_t'(lat * `TRC_TIMEOUT_MULT);
	endfunction

	wire trc_pkg::trc_count_t rawTimeout = trc_unadj(maxPayload, linkLanes);
	// Subtract own receiver L0s exit time, never below one
	wire adjFits = rawTimeout > rxL0sAdj;
	wire trc_pkg::trc_count_t adjTimeout = adjFits ? rawTimeout - rxL0sAdj : `TRC_TMR_W'(1);

	// Registered to keep the divider out of the timer path
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			threshold <= '1;
		end else begin
			threshold <= adjTimeout;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// x1 corner values of the formula
	x1_small_a: assert property (maxPayload == 3'h0 && linkLanes == 5'h01 |-> rawTimeout == 16'd711)
		else $error("x1 128B timeout wrong");
	x1_large_a: assert property (maxPayload == 3'h5 && linkLanes == 5'h01 |-> rawTimeout == 16'd12429)
		else $error("x1 4096B timeout wrong");
endmodule
`default_nettype wire

// File: test/trc_link_partner.sv
`default_nettype none
module trc_link_partner (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic txValid,
	input wire logic [31:0] txData,
	input wire logic stall,
	input wire logic extLast,
	output logic txReady,
	output logic txLastSym,
	output logic [31:0] lastWord
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sent_q;
	// Stall models a slow receiver that backs up the buffer
	assign txReady = !stall;
	// One word is one packet; its last symbol leaves a cycle later
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sent_q <= 1'b0;
			lastWord <= 32'h00000000;
		end else begin
			sent_q <= txValid && txReady;
			if (txValid && txReady) lastWord <= txData;
		end
	end
	// Resends come from the retry buffer, so the bench injects them
	assign txLastSym = sent_q || extLast;
endmodule
`default_nettype wire

// File: test/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, nrst, tlValid, tlReady, txValid, txReady, txLastSym, txIsRetx;
	logic ackRcvd, ackAdvances, nakRcvd, unackPending, linkUp, ltssmRetrain;
	logic retrainDone, replayDone, ackLinkL0sExit, stall, extLast;
	logic replayStart, replayActive, retrainReq, portError, timerRunning;
	logic [31:0] tlData, txData, lastWord;
	logic [2:0] maxPayload;
	logic [4:0] linkLanes;
	logic [15:0] rxL0sAdj;
	logic [1:0] replayNum;
	trc_pkg::trc_count_t timerCount;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	trc_replay_ctl u_dut (.mclk, .nrst, .tlValid, .tlData, .tlReady, .txValid, .txData, .txReady,
		.txLastSym, .txIsRetx, .ackRcvd, .ackAdvances, .nakRcvd, .unackPending, .linkUp,
		.ltssmRetrain, .retrainDone, .replayDone, .maxPayload, .linkLanes, .rxL0sAdj,
		.ackLinkL0sExit, .replayStart, .replayActive, .retrainReq, .portError, .replayNum,
		.timerRunning, .timerCount);
	trc_link_partner u_peer (.mclk, .nrst, .txValid, .txData, .stall, .extLast, .txReady,
		.txLastSym, .lastWord);
	// 25 MHz
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Cut a hung run short
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			test_done();
		end
	end
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			$display("Error %s expected %0h seen %0h", what, exp, seen);
			n_mismatch++;
		end
	endtask
	// One-cycle strobe: 0 last symbol, 1 ack, 2 nak, 3 retrain done, 4 replay done
	task pulse(input int k);
		@(posedge mclk);
		case (k)
			0: extLast <= 1'b1;
			1: ackRcvd <= 1'b1;
			2: nakRcvd <= 1'b1;
			3: retrainDone <= 1'b1;
			default: replayDone <= 1'b1;
		endcase
		@(posedge mclk);
		{extLast, ackRcvd, nakRcvd, retrainDone, replayDone, txIsRetx} <= 6'h00;
		@(negedge mclk);
	endtask
	function automatic logic sig(int k);
		case (k)
			0: return replayStart;
			1: return retrainReq;
			default: return !replayActive;
		endcase
	endfunction
	// Bounded wait, sampled mid-cycle so registered outputs are settled
	task waitSig(input int k, input int lim);
		for (int i = 0; i < lim && sig(k) !== 1'b1; i++) @(negedge mclk);
		check("wait", sig(k), 1'b1);
	endtask
	task tFifo;
		int n, i;
		logic r;
		n = 0;
		@(posedge mclk);
		stall <= 1'b1;
		tlValid <= 1'b1;
		tlData <= 32'h00000000;
		for (i = 0; i < 30; i++) begin
			@(negedge mclk);
			r = tlReady;
			@(posedge mclk);
			if (r) begin
				n++;
				tlData <= n;
			end
		end
		tlValid <= 1'b0;
		stall <= 1'b0;
		check("fillCount", (n >= 15 && n <= 17), 1'b1);
		i = 0;
		repeat (60) begin
			@(negedge mclk);
			if (txValid && txReady) begin
				check("txData", txData, i);
				i++;
			end
		end
		check("drainCount", i, n);
		check("lastWord", lastWord, n - 1);
		check("idleTimer", timerRunning, 1'b0);
		$display("fifo test done");
	endtask
	task tTimer;
		trc_pkg::trc_count_t v;
		@(posedge mclk);
		unackPending <= 1'b1;
		pulse(0);
		check("runStart", {timerRunning, timerCount}, 17'h10000);
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		check("cntRun", timerCount, 10);
		@(posedge mclk);
		ltssmRetrain <= 1'b1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		v = timerCount;
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		check("hold", timerCount, v);
		@(posedge mclk);
		ltssmRetrain <= 1'b0;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		check("resume", timerCount, v + 5);
		pulse(1);
		check("ackNoAdv", timerCount, v + 7);
		@(posedge mclk);
		ackAdvances <= 1'b1;
		pulse(1);
		check("ackAdv", {timerRunning, timerCount}, 17'h10000);
		@(posedge mclk);
		ackAdvances <= 1'b0;
		unackPending <= 1'b0;
		@(posedge mclk);
		@(negedge mclk);
		check("noUnack", {timerRunning, timerCount}, 17'h00000);
		$display("timer test done");
	endtask
	task tReplay(input logic [1:0] expNum, input bit wrap);
		@(posedge mclk);
		unackPending <= 1'b1;
		pulse(0);
		pulse(2);
		check("active", replayActive, 1'b1);
		check("nakClr", timerRunning, 1'b0);
		check("tlBlock", tlReady, 1'b0);
		if (wrap) begin
			waitSig(1, 4);
			check("portErr", portError, 1'b1);
			check("wrapNum", replayNum, 2'h0);
			repeat (8) @(negedge mclk);
			check("waitTrain", replayStart, 1'b0);
			check("keepState", replayActive, 1'b1);
			pulse(3);
		end
		waitSig(0, 4);
		check("num", replayNum, expNum);
		@(posedge mclk);
		txIsRetx <= 1'b1;
		pulse(0);
		check("retxStart", {timerRunning, timerCount}, 17'h10000);
		pulse(2);
		check("nakInReplay", timerRunning, 1'b1);
		check("oneReplay", replayActive, 1'b1);
		pulse(4);
		waitSig(2, 3);
		@(negedge mclk);
		check("tlFree", tlReady, 1'b1);
		$display("replay test done");
	endtask
	task tAbort;
		logic seen;
		pulse(2);
		waitSig(0, 4);
		check("num1", replayNum, 2'h1);
		@(posedge mclk);
		linkUp <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check("downIdle", replayActive, 1'b0);
		check("downNum", replayNum, 2'h0);
		@(posedge mclk);
		linkUp <= 1'b1;
		unackPending <= 1'b0;
		pulse(2);
		seen = 1'b0;
		repeat (4) begin
			@(negedge mclk);
			seen = seen | replayStart;
		end
		check("abandonStart", seen, 1'b0);
		check("abandonIdle", replayActive, 1'b0);
		check("abandonNum", replayNum, 2'h0);
		$display("abort test done");
	endtask
	task tExpiry(input logic [2:0] mps, input logic [4:0] w, input logic [15:0] adj, input int exp, input bit l0s);
		trc_pkg::trc_count_t mx;
		@(posedge mclk);
		maxPayload <= mps;
		linkLanes <= w;
		rxL0sAdj <= adj;
		ackLinkL0sExit <= l0s;
		unackPending <= 1'b1;
		ackAdvances <= 1'b1;
		repeat (2) @(posedge mclk);
		pulse(1);
		@(posedge mclk);
		ackAdvances <= 1'b0;
		pulse(0);
		mx = '0;
		for (int i = 0; i < 13000 && replayActive !== 1'b1 && !(l0s && i > exp + 20); i++) begin
			@(negedge mclk);
			if (timerCount > mx) mx = timerCount;
		end
		check("peak", mx, exp);
		if (l0s) begin
			check("l0sHold", replayActive, 1'b0);
			@(posedge mclk);
			ackLinkL0sExit <= 1'b0;
		end
		waitSig(0, 6);
		pulse(4);
		waitSig(2, 3);
		$display("expiry test done");
	endtask
	initial begin
		{tlValid, txIsRetx, ackRcvd, ackAdvances, nakRcvd, unackPending} = 6'h00;
		{ltssmRetrain, retrainDone, replayDone, ackLinkL0sExit, stall, extLast} = 6'h00;
		tlData = 32'h00000000;
		maxPayload = 3'h0;
		linkLanes = 5'h01;
		rxL0sAdj = 16'h0000;
		linkUp = 1'b1;
		nrst = 1'b0;
		repeat (3) @(posedge mclk);
		check("rstReady", tlReady, 1'b0);
		nrst <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		check("outReady", tlReady, 1'b1);
		check("rstNum", replayNum, 2'h0);
		tFifo();
		tTimer();
		for (int k = 1; k < 4; k++) tReplay(2'(k), 1'b0);
		tReplay(2'h0, 1'b1);
		tAbort();
		tExpiry(3'h0, 5'h01, 16'h0000, 711, 1'b0);
		tExpiry(3'h3, 5'h01, 16'h0000, 3213, 1'b0);
		tExpiry(3'h5, 5'h01, 16'h0000, 12429, 1'b0);
		tExpiry(3'h0, 5'h08, 16'h0000, 201, 1'b0);
		tExpiry(3'h0, 5'h01, 16'h0064, 611, 1'b0);
		tExpiry(3'h0, 5'h01, 16'h0000, 711, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
